// >>> rtl/two_wire_register_slave.v
// two-wire serial slave with the sensor control register map
//
// How it works
// (RULE1) ninth pulse: sender releases, receiver pulls low
// (RULE2) high data on ninth pulse means no-acknowledge
// (RULE3) 8-bit address picks one of 256 words
// (RULE4) 3-bit page prefix held at location F0
// (RULE5) page zero after reset reaches every register
// (RULE6) write: address byte then data, all acknowledged
// (RULE7) register changes only after sixteen data bits
// (RULE8) address advances after each written word
// (RULE9) start or stop ends a write burst
// (RULE10) master writes address, then restarts to read
// (RULE11) reads send upper byte first, then advance
// (RULE12) release data line after master no-acknowledge
// (RULE13) held upper byte commits with low byte at F1
// (RULE14) half a register is never committed
// (RULE15) read at F1 returns target's low byte
// (RULE16) master avoids unlisted and reserved locations
// (RULE17) listed registers load defaults on reset
// (RULE18) answer default or alternate device address
// (RULE19) data edges with clock high are start/stop
// (RULE20) standby blocks writes to alternate address bit
// (RULE21) foreign device address gets no acknowledge
// (RULE22) fixed zero bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_slave_regs.vh"

module two_wire_register_slave #(
    parameter [15:0] CHIP_IDENTITY = 16'hA5C3 // arbitrary identity value
) (
    input wire clock,
    input wire rstn,
    input wire clock_enable,
    input wire serial_clock,
    input wire serial_data_in,
    output reg serial_data_out,
    output reg serial_data_oe,
    input wire alt_address_select_pin,
    input wire standby,
    output reg [2:0] page_selected,
    output reg busy
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam N = `ENTRY_COUNT;
    localparam [2:0] ST_IDLE = 3'h0; // waiting for a start
    localparam [2:0] ST_DEV = 3'h1; // receiving device address
    localparam [2:0] ST_REGADDR = 3'h2; // receiving register address
    localparam [2:0] ST_WDATA = 3'h3; // receiving data bytes
    localparam [2:0] ST_RDATA = 3'h4; // sending data bytes
    localparam [3:0] ACK_SLOT = 4'h8; // ninth pulse of a byte
    localparam [3:0] LAST_BIT = 4'h7; // eighth pulse of a byte
    localparam [3:0] PRE_FIRST = 4'hF; // wraps to zero on start's fall

    // ----------------------------------------------------------------
    // entry table lookup
    // ----------------------------------------------------------------
    // one entry per listed word: offset, reset value, writable mask
    function [39:0] entry;
        input integer pos;
        begin
            case (pos)
                6'd0: entry = `ENT_FIRST_ROW;
                6'd1: entry = `ENT_FIRST_COLUMN;
                6'd2: entry = `ENT_WINDOW_ROWS;
                6'd3: entry = `ENT_WINDOW_COLUMNS;
                6'd4: entry = `ENT_LINE_BLANK_SECOND_CTX;
                6'd5: entry = `ENT_FRAME_BLANK_SECOND_CTX;
                6'd6: entry = `ENT_LINE_BLANK_FIRST_CTX;
                6'd7: entry = `ENT_FRAME_BLANK_FIRST_CTX;
                6'd8: entry = `ENT_EXPOSURE_ROWS;
                6'd9: entry = `ENT_READOUT_RATE;
                6'd10: entry = `ENT_ADDED_DELAY;
                6'd11: entry = `ENT_EXPOSURE_DELAY;
                6'd12: entry = `ENT_RESTART_CONTROL;
                6'd13: entry = `ENT_FRAME_FLAG_CONTROL;
                6'd14: entry = `ENT_READOUT_CFG_SECOND_CTX;
                6'd15: entry = `ENT_READOUT_CFG_FIRST_CTX;
                6'd16: entry = `ENT_SHIELDED_LINES;
                6'd17: entry = `ENT_STROBE_CONTROL;
                6'd18: entry = `ENT_ADDED_ROW_RESET;
                6'd19: entry = `ENT_LINE_FLAG_CONTROL;
                6'd20: entry = `ENT_LOWER_SHIELDED_ROWS;
                6'd21: entry = `ENT_GAIN_GREEN_FIRST;
                6'd22: entry = `ENT_GAIN_BLUE;
                6'd23: entry = `ENT_GAIN_RED;
                6'd24: entry = `ENT_GAIN_GREEN_SECOND;
                6'd25: entry = `ENT_GAIN_ALL_CHANNELS;
                6'd26: entry = `ENT_LINE_NOISE_CFG;
                6'd27: entry = `ENT_RESERVED_31;
                6'd28: entry = `ENT_RESERVED_32;
                6'd29: entry = `ENT_RESERVED_33;
                6'd30: entry = `ENT_RESERVED_34;
                6'd31: entry = `ENT_RESERVED_35;
                6'd32: entry = `ENT_RESERVED_36;
                6'd33: entry = `ENT_RESERVED_38;
                6'd34: entry = `ENT_RESERVED_3B;
                6'd35: entry = `ENT_RESERVED_3C;
                default: entry = 40'h00_0000_0000;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [2:0] scl_sync; // [0] raw, [1] clean, [2] previous
    reg [2:0] sda_sync; // same layout as clock line
    reg [1:0] pin_sync; // address select pin synchroniser
    reg [1:0] stby_sync; // standby synchroniser
    reg [2:0] state; // protocol state
    reg [3:0] bit_cnt; // pulse count within a byte
    reg [7:0] rx; // incoming shift register
    reg [7:0] tx; // outgoing shift register
    reg [7:0] reg_addr; // current register address
    reg byte_pos; // 0: upper byte next, 1: lower byte
    reg [7:0] hold_hi; // upper byte awaiting its partner
    reg [5:0] tgt_idx; // entry the held byte belongs to
    reg tgt_ok; // held byte has a writable target
    reg tgt_page; // held byte targets the page register
    reg [7:0] low_latch; // low byte of the last word read
    reg [15:0] bank [0:N-1]; // register storage
    reg wr_pulse; // one-cycle commit strobe
    reg wr_page; // commit goes to the page register
    reg [5:0] wr_idx; // entry to commit
    reg [15:0] wr_data; // full word to commit
    reg [2:0] page; // page prefix

    // ----------------------------------------------------------------
    // combinational decode
    // ----------------------------------------------------------------
    wire scl_s = scl_sync[1];
    wire scl_p = scl_sync[2];
    wire sda_s = sda_sync[1];
    wire sda_p = sda_sync[2];
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    // (RULE19) start and stop detection
    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = scl_s & scl_p & ~sda_p & sda_s;

    // (RULE18) alternate pair when exactly one select is low
    wire alt_bit = bank[12][`ALT_ADDRESS_BIT];
    wire use_alt = pin_sync[1] ^ alt_bit;
    wire [7:0] my_addr = use_alt ? `DEV_ADDR_ALT : `DEV_ADDR_DEFAULT;

    reg hit; // current address is a listed entry
    reg [5:0] idx; // entry index of current address
    reg [39:0] ent; // scratch entry
    reg [15:0] rd_value; // word shown at current address
    integer k;
    integer j; // loop index of the storage process
    wire [39:0] ent_tab [0:N-1]; // fixed table rows
    genvar g;

    // one constant row per listed word, shared by the address lookup and the storage process
    generate
        for (g = 0; g < N; g = g + 1) begin : tab
            assign ent_tab[g] = entry(g);
        end
    endgenerate

    // (RULE3) match the 8-bit address against the entry table
    always @* begin
        hit = 1'b0;
        idx = 6'h00;
        ent = 40'h00_0000_0000;
        for (k = 0; k < N; k = k + 1) begin
            ent = ent_tab[k];
            if (ent[39:32] == reg_addr) begin
                hit = 1'b1;
                idx = k[5:0];
            end
        end
    end

    // value read at the current address; unlisted reads zero except the identity and page words
    always @* begin
        // (RULE4) page register stays reachable on any page
        if (reg_addr == `OFS_PAGE_SELECT) begin
            rd_value = {13'h0000, page};
        // (RULE5) sensor words only appear on page zero
        end else if (page != 3'h0) begin
            rd_value = 16'h0000;
        end else if (reg_addr == `OFS_CHIP_IDENTITY) begin
            rd_value = CHIP_IDENTITY;
        end else if (hit) begin
            rd_value = bank[idx];
        end else begin
            rd_value = 16'h0000;
        end
    end

    // writable target check for the current address
    wire map_ok = (reg_addr == `OFS_PAGE_SELECT) |
                  ((page == 3'h0) & hit);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // line inputs cross in from the master; third stage only for edges
    always @(posedge clock) begin
        if (!rstn) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            pin_sync <= 2'h0;
            stby_sync <= 2'h0;
        end else if (clock_enable) begin
            scl_sync <= {scl_sync[1:0], serial_clock};
            sda_sync <= {sda_sync[1:0], serial_data_in};
            pin_sync <= {pin_sync[0], alt_address_select_pin};
            stby_sync <= {stby_sync[0], standby};
        end
    end

    // ----------------------------------------------------------------
    // protocol engine
    // ----------------------------------------------------------------
    // sample on rising clock, drive on falling clock so data only
    // changes while the serial clock is low
    always @(posedge clock) begin
        if (!rstn) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            reg_addr <= 8'h00;
            byte_pos <= 1'b0;
            hold_hi <= 8'h00;
            tgt_idx <= 6'h00;
            tgt_ok <= 1'b0;
            tgt_page <= 1'b0;
            low_latch <= 8'h00;
            wr_pulse <= 1'b0;
            wr_page <= 1'b0;
            wr_idx <= 6'h00;
            wr_data <= 16'h0000;
            serial_data_oe <= 1'b0;
            serial_data_out <= 1'b0;
            busy <= 1'b0;
        end else if (clock_enable) begin
            wr_pulse <= 1'b0;
            serial_data_out <= 1'b0;
            busy <= (state != ST_IDLE);
            // (RULE9) start or stop ends any burst
            if (start_det | stop_det) begin
                state <= start_det ? ST_DEV : ST_IDLE;
                // the start's own clock fall must not count as a bit
                bit_cnt <= start_det ? PRE_FIRST : 4'h0;
                byte_pos <= 1'b0;
                serial_data_oe <= 1'b0;
            end else if (scl_rise && state != ST_IDLE) begin
                if (bit_cnt < ACK_SLOT) begin
                    rx <= {rx[6:0], sda_s};
                // (RULE2) high on the ack pulse is a no-acknowledge
                end else if (state == ST_RDATA && sda_s) begin
                    // (RULE12) stop driving, wait for the next start
                    state <= ST_IDLE;
                    serial_data_oe <= 1'b0;
                end
            end else if (scl_fall && state != ST_IDLE) begin
                if (state == ST_RDATA) begin
                    if (bit_cnt == ACK_SLOT) begin
                        // (RULE11) upper byte first, advance per word
                        if (reg_addr == `OFS_LOW_BYTE_ACCESS) begin
                            // (RULE15) low byte of the last target
                            tx <= low_latch;
                            serial_data_oe <= ~low_latch[7];
                        end else if (!byte_pos) begin
                            tx <= rd_value[15:8];
                            serial_data_oe <= ~rd_value[15];
                            low_latch <= rd_value[7:0];
                            byte_pos <= 1'b1;
                        end else begin
                            tx <= rd_value[7:0];
                            serial_data_oe <= ~rd_value[7];
                            reg_addr <= reg_addr + 8'h01;
                            byte_pos <= 1'b0;
                        end
                        bit_cnt <= 4'h0;
                    end else if (bit_cnt == LAST_BIT) begin
                        // (RULE1) sender lets go for the ack pulse
                        serial_data_oe <= 1'b0;
                        bit_cnt <= ACK_SLOT;
                    end else begin
                        // open drain: enable means pull low
                        serial_data_oe <= ~tx[6];
                        tx <= {tx[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end else if (bit_cnt == ACK_SLOT) begin
                    // (RULE1) release after our acknowledge
                    serial_data_oe <= 1'b0;
                    bit_cnt <= 4'h0;
                end else if (bit_cnt != LAST_BIT) begin
                    bit_cnt <= bit_cnt + 4'h1;
                end else begin
                    bit_cnt <= ACK_SLOT;
                    case (state)
                        ST_DEV: begin
                            // (RULE21) foreign address: stay off line
                            if (rx[7:1] == my_addr[7:1]) begin
                                // (RULE1) receiver pulls the line low
                                serial_data_oe <= 1'b1;
                                state <= rx[0] ? ST_RDATA : ST_REGADDR;
                                byte_pos <= 1'b0;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                        ST_REGADDR: begin
                            // (RULE6) first byte is the register address
                            reg_addr <= rx;
                            serial_data_oe <= 1'b1;
                            state <= ST_WDATA;
                            byte_pos <= 1'b0;
                        end
                        ST_WDATA: begin
                            // (RULE6) every data byte acknowledged
                            serial_data_oe <= 1'b1;
                            if (reg_addr == `OFS_LOW_BYTE_ACCESS) begin
                                // (RULE13) low byte completes held word
                                wr_pulse <= tgt_ok;
                                wr_page <= tgt_page;
                                wr_idx <= tgt_idx;
                                wr_data <= {hold_hi, rx};
                            end else if (!byte_pos) begin
                                // (RULE7) upper byte only held
                                hold_hi <= rx;
                                tgt_idx <= idx;
                                tgt_ok <= map_ok;
                                tgt_page <= (reg_addr == `OFS_PAGE_SELECT);
                                byte_pos <= 1'b1;
                            end else begin
                                // (RULE14) full word assembled, commit
                                wr_pulse <= map_ok;
                                wr_page <= (reg_addr == `OFS_PAGE_SELECT);
                                wr_idx <= idx;
                                wr_data <= {hold_hi, rx};
                                // (RULE8) next word to next register
                                reg_addr <= reg_addr + 8'h01;
                                byte_pos <= 1'b0;
                            end
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    // (RULE17) each listed word loads its default on reset
    always @(posedge clock) begin
        for (j = 0; j < N; j = j + 1) begin
            if (!rstn) begin
                bank[j] <= ent_tab[j][31:16];
            end else if (clock_enable && wr_pulse && !wr_page &&
                         wr_idx == j[5:0]) begin
                // (RULE22) fixed-zero positions keep zero
                bank[j] <= wr_data & ent_tab[j][15:0];
                // (RULE20) standby freezes the alternate address bit
                if (ent_tab[j][39:32] == `OFS_RESTART_CONTROL &&
                    stby_sync[1])
                    bank[j][`ALT_ADDRESS_BIT] <=
                        bank[j][`ALT_ADDRESS_BIT];
            end
        end
    end

    // (RULE4) page prefix register, only three bits stored
    always @(posedge clock) begin
        if (!rstn) begin
            // (RULE5) page zero selected after reset
            page <= `PAGE_RESET;
            page_selected <= `PAGE_RESET;
        end else if (clock_enable) begin
            if (wr_pulse && wr_page)
                page <= wr_data[2:0];
            page_selected <= page;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/two_wire_slave_regs.vh
// register offsets, reset values and writable masks of the serial slave
`ifndef TWO_WIRE_SLAVE_REGS_VH
`define TWO_WIRE_SLAVE_REGS_VH

// ----------------------------------------------------------------
// special locations and protocol constants
// ----------------------------------------------------------------
`define OFS_CHIP_IDENTITY 8'h00
`define OFS_RESTART_CONTROL 8'h0D
`define OFS_PAGE_SELECT 8'hF0
`define OFS_LOW_BYTE_ACCESS 8'hF1
`define PAGE_RESET 3'h0
`define ALT_ADDRESS_BIT 10
`define DEV_ADDR_DEFAULT 8'hBA
`define DEV_ADDR_ALT 8'h90
`define ENTRY_COUNT 36

// ----------------------------------------------------------------
// entries: {offset, reset value, writable mask}
// ----------------------------------------------------------------
`define ENT_FIRST_ROW {8'h01, 16'h001C, 16'h07FF}
`define ENT_FIRST_COLUMN {8'h02, 16'h003C, 16'h07FF}
`define ENT_WINDOW_ROWS {8'h03, 16'h04B0, 16'h07FF}
`define ENT_WINDOW_COLUMNS {8'h04, 16'h0640, 16'h07FF}
`define ENT_LINE_BLANK_SECOND_CTX {8'h05, 16'h015C, 16'h3FFF}
`define ENT_FRAME_BLANK_SECOND_CTX {8'h06, 16'h0020, 16'h7FFF}
`define ENT_LINE_BLANK_FIRST_CTX {8'h07, 16'h00AE, 16'h3FFF}
`define ENT_FRAME_BLANK_FIRST_CTX {8'h08, 16'h0010, 16'h7FFF}
`define ENT_EXPOSURE_ROWS {8'h09, 16'h04D0, 16'hFFFF}
`define ENT_READOUT_RATE {8'h0A, 16'h0011, 16'hE0F7}
`define ENT_ADDED_DELAY {8'h0B, 16'h0000, 16'h3FFF}
`define ENT_EXPOSURE_DELAY {8'h0C, 16'h0000, 16'h3FFF}
`define ENT_RESTART_CONTROL {8'h0D, 16'h0000, 16'h87F7}
`define ENT_FRAME_FLAG_CONTROL {8'h1F, 16'h0000, 16'hFFFF}
`define ENT_READOUT_CFG_SECOND_CTX {8'h20, 16'h0000, 16'hBFFF}
`define ENT_READOUT_CFG_FIRST_CTX {8'h21, 16'h0490, 16'h84FC}
`define ENT_SHIELDED_LINES {8'h22, 16'h010F, 16'h07FF}
`define ENT_STROBE_CONTROL {8'h23, 16'h0608, 16'h3FFF}
`define ENT_ADDED_ROW_RESET {8'h24, 16'h8000, 16'hC000}
`define ENT_LINE_FLAG_CONTROL {8'h25, 16'h0000, 16'hC000}
`define ENT_LOWER_SHIELDED_ROWS {8'h26, 16'h0007, 16'h00FF}
`define ENT_GAIN_GREEN_FIRST {8'h2B, 16'h0020, 16'h0FFF}
`define ENT_GAIN_BLUE {8'h2C, 16'h0020, 16'h0FFF}
`define ENT_GAIN_RED {8'h2D, 16'h0020, 16'h0FFF}
`define ENT_GAIN_GREEN_SECOND {8'h2E, 16'h0020, 16'h0FFF}
`define ENT_GAIN_ALL_CHANNELS {8'h2F, 16'h0020, 16'h0FFF}
`define ENT_LINE_NOISE_CFG {8'h30, 16'h042A, 16'hFFFF}
`define ENT_RESERVED_31 {8'h31, 16'h0000, 16'hFFFF}
`define ENT_RESERVED_32 {8'h32, 16'h02AA, 16'hFFFF}
`define ENT_RESERVED_33 {8'h33, 16'h0341, 16'hFFFF}
`define ENT_RESERVED_34 {8'h34, 16'h000F, 16'hFFFF}
`define ENT_RESERVED_35 {8'h35, 16'h0EE8, 16'hFFFF}
`define ENT_RESERVED_36 {8'h36, 16'hF0F0, 16'hFFFF}
`define ENT_RESERVED_38 {8'h38, 16'h0808, 16'hFFFF}
`define ENT_RESERVED_3B {8'h3B, 16'h0020, 16'hFFFF}
`define ENT_RESERVED_3C {8'h3C, 16'h2020, 16'hFFFF}

`endif

// >>> test/bus_watch_properties.sv
// port-level checks of the two-wire register slave
`timescale 1ns/1ps
`default_nettype none
module bus_watch (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clock_enable,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic alt_address_select_pin,
    input wire logic standby,
    input wire logic [2:0] page_selected,
    input wire logic busy
);
    // ----
    // one domain, so a shared clock and reset
    // ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    reset_quiet_a: assert property (
        $rose(rstn) |-> !serial_data_oe && !busy && page_selected == 3'h0)
        else $error("outputs not quiet after reset");
    data_out_low_a: assert property (
        serial_data_out == 1'b0)
        else $error("data pin driven high");
    // the device may only move the wire while the clock is low
    oe_moves_low_a: assert property (
        $changed(serial_data_oe) |-> !serial_clock)
        else $error("data enable moved with clock high");
    oe_holds_high_a: assert property (
        $rose(serial_clock) |=> $stable(serial_data_oe) [*8])
        else $error("data enable moved during clock pulse");
    start_busy_a: assert property (
        serial_clock && $fell(serial_data_in) |-> ##[1:8] busy)
        else $error("start not taken");
    stop_idle_a: assert property (
        serial_clock && $rose(serial_data_in) |-> ##[1:8] !busy)
        else $error("stop did not end transfer");
    idle_release_a: assert property (
        !busy |-> !serial_data_oe)
        else $error("data wire held while idle");
    page_in_xfer_a: assert property (
        $changed(page_selected) |-> busy)
        else $error("page moved outside a transfer");
    cover property (busy && serial_data_oe);
    cover property ($fell(busy));
    cover property ($changed(page_selected));
endmodule
`default_nettype wire

// >>> test/master_model.sv
// two-wire bus master: drives the clock and pulls the data wire
`timescale 1ns/1ps
`default_nettype none
module master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // lines move by non-blocking assignment on clock edges: race free
    // data moves only while clock low
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        #40 scl <= 1'b1;
        #40 r = sda;
        #40 scl <= 1'b0;
        #40;
    endtask
    task automatic start();
        sda_low <= 1'b0;
        #40 scl <= 1'b1;
        #40 sda_low <= 1'b1;
        #40 scl <= 1'b0;
        #40;
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        #40 scl <= 1'b1;
        #40 sda_low <= 1'b0;
        #40;
    endtask
    // eight bits msb first, then the ninth pulse
    task automatic xfer(input logic [7:0] d, input logic ak,
                        output logic [7:0] q, output logic ar);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ak, ar);
    endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the two-wire register slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [15:0] ID = 16'h5A5A; // arbitrary identity value
    logic clock = 1'b0, rstn = 1'b0, alt_pin = 1'b0, standby = 1'b0;
    logic scl, sda_low, oe, dout, busy, a;
    logic [2:0] page;
    logic [7:0] dev = 8'hBA, q;
    logic [15:0] w;
    int err_count = 0, checked = 0, cyc = 0;
    wire logic sda = ~(sda_low | oe); // pull-up unless someone pulls
    // rows: offset, written, read back // listed words plus the identity word at 00
    logic [39:0] rows [6] = '{{8'h09, 16'hFFFF, 16'hFFFF},
        {8'h01, 16'hFFFF, 16'h07FF}, {8'h0A, 16'hFFFF, 16'hE0F7},
        {8'h24, 16'hFFFF, 16'hC000}, {8'h00, 16'h0000, ID},
        {8'h25, 16'hFFFF, 16'hC000}};
    logic [7:0] wb [5] = '{8'h11, 8'h12, 8'h21, 8'h22, 8'h33};
    always #2.5 clock = ~clock;
    master_model u_master_model (.scl(scl), .sda_low(sda_low), .sda(sda));
    two_wire_register_slave #(.CHIP_IDENTITY(ID)) u_two_wire_register_slave (
        .clock(clock), .rstn(rstn), .clock_enable(1'b1),
        .serial_clock(scl), .serial_data_in(sda), .serial_data_out(dout),
        .serial_data_oe(oe), .alt_address_select_pin(alt_pin),
        .standby(standby), .page_selected(page), .busy(busy));
    task automatic close_out();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic put(input logic [7:0] d, input logic ak);
        u_master_model.xfer(d, 1'b1, q, a);
        chk({15'h0, a}, {15'h0, ak});
    endtask
    task automatic get(input logic ak);
        u_master_model.xfer(8'hFF, ak, q, a);
    endtask
    task automatic hdr(input logic [7:0] r);
        u_master_model.start();
        put(dev, 1'b0);
        put(r, 1'b0);
    endtask
    task automatic wr(input logic [7:0] r, input logic [15:0] v);
        hdr(r);
        put(v[15:8], 1'b0);
        put(v[7:0], 1'b0);
        u_master_model.stop();
    endtask
    task automatic wrb(input logic [7:0] r, input logic [7:0] d);
        hdr(r);
        put(d, 1'b0);
        u_master_model.stop();
    endtask
    // address write, repeated start, then read (ack, nack)
    task automatic rd(input logic [7:0] r, input logic [15:0] e, int n);
        hdr(r);
        u_master_model.start();
        put(dev | 8'h01, 1'b0);
        for (int i = 0; i < n; i++) begin
            get(i == n - 1);
            w = {w[7:0], q};
        end
        u_master_model.stop();
        chk(n == 2 ? w : {8'h00, q}, e);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (rows[i]) begin
            wr(rows[i][39:32], rows[i][31:16]);
            rd(rows[i][39:32], rows[i][15:0], 2);
        end
        $display("rows done");
        @(posedge clock);
        rstn <= 1'b0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        chk({13'h0, page}, 16'h0000);
        rd(8'h09, 16'h04D0, 2);
        rd(8'h03, 16'h04B0, 2);
        rd(8'h04, 16'h0640, 2);
        $display("reset done");
        wr(8'hF0, 16'h0003);
        chk({13'h0, page}, 16'h0003);
        rd(8'h09, 16'h0000, 2);
        wr(8'hF0, 16'h0000);
        rd(8'h09, 16'h04D0, 2);
        hdr(8'h0B);
        foreach (wb[i]) put(wb[i], 1'b0);
        u_master_model.stop();
        rd(8'h0C, 16'h2122, 2);
        rd(8'h0D, 16'h0000, 2);
        hdr(8'h0B);
        u_master_model.start();
        put(dev | 8'h01, 1'b0);
        for (int i = 0; i < 4; i++) begin
            get(i == 3);
            chk({8'h00, q}, {8'h00, wb[i]});
        end
        chk({15'h0, oe}, 16'h0000);
        u_master_model.stop();
        wrb(8'h09, 8'h02);
        wrb(8'hF1, 8'h84);
        rd(8'h09, 16'h0284, 2);
        rd(8'h09, 16'h0002, 1);
        rd(8'hF1, 16'h0084, 1);
        u_master_model.start();
        put(8'h20, 1'b1);
        u_master_model.stop();
        @(posedge clock);
        standby <= 1'b1;
        repeat (4) @(posedge clock);
        wr(8'h0D, 16'h0401);
        rd(8'h0D, 16'h0001, 2);
        @(posedge clock);
        standby <= 1'b0;
        repeat (4) @(posedge clock);
        wr(8'h0D, 16'h0401);
        u_master_model.start();
        put(8'hBA, 1'b1);
        u_master_model.stop();
        dev = 8'h90;
        rd(8'h0D, 16'h0401, 2);
        @(posedge clock);
        alt_pin <= 1'b1;
        repeat (4) @(posedge clock);
        dev = 8'hBA;
        rd(8'h0D, 16'h0401, 2);
        $display("awkward done");
        close_out();
    end
    // hang guard, well above the expected run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            err_count++;
            close_out();
        end
    end
endmodule
bind two_wire_register_slave bus_watch u_bus_watch (.clock(clock),
    .rstn(rstn), .clock_enable(clock_enable), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .standby(standby),
    .alt_address_select_pin(alt_address_select_pin),
    .page_selected(page_selected), .busy(busy));
`default_nettype wire
